/* File: dv/ovr_embed_chk_sva.sv */
// port checker for the over-range flag embedder
// assumes flush of at least 4 cycles and one sample clock
`include "ovr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ovr_embed_chk #(
  parameter int FLUSH_SAMPLES = 64
) (
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire ovr_pkg::reg_req_t reg_req,
  input wire logic [31:0]       reg_rdata,
  input wire logic [11:0]       raw_sample,
  input wire ovr_pkg::iq_word_t ddc_word,
  input wire logic              ddc_valid,
  input wire ovr_pkg::iq_word_t out_word,
  input wire logic              out_valid,
  input wire logic              tx_drive_en,
  input wire logic              link_restart,
  input wire logic              irq
);
  logic              pd_q;
  logic [15:0]       thr_q;
  logic [8:0]        quiet_q;
  logic [8:0]        loud_q;
  ovr_pkg::iq_word_t ddc_q;
  always_ff @(posedge ref_clk) begin
    if (rst) pd_q <= 1'b0;
    else if (reg_req.we && reg_req.addr == `OVR_REG_CTRL) pd_q <= reg_req.wdata[0];
  end
  always_ff @(posedge ref_clk) begin
    if (rst) thr_q <= 16'h40E4;
    else if (reg_req.we && reg_req.addr == `OVR_REG_THR) thr_q <= reg_req.wdata[15:0];
  end
  always_ff @(posedge ref_clk) ddc_q <= ddc_word;
  // cycles of steady quiet or full-scale input since any write
  always_ff @(posedge ref_clk) begin
    if (rst || pd_q || reg_req.we) begin
      quiet_q <= 9'h000;
      loud_q <= 9'h000;
    end else begin
      quiet_q <= (raw_sample[11:3] != 9'h100) ? 9'h000 : quiet_q + {8'h00, quiet_q != 9'h1FF};
      loud_q <= (raw_sample != 12'hFFF && raw_sample != 12'h000) ? 9'h000
                : loud_q + {8'h00, loud_q != 9'h1FF};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  pd_drive_off_a: assert property (pd_q && $past(pd_q) && $past(pd_q, 2) |-> !tx_drive_en)
    else $error("driver on in power-down");
  pd_no_out_a: assert property (pd_q && $past(pd_q) && $past(pd_q, 2) |-> !out_valid)
    else $error("output in power-down");
  restart_link_a: assert property ($fell(pd_q) |-> ##[1:4] link_restart)
    else $error("no link restart");
  flush_quiet_a: assert property (link_restart |-> !out_valid [*3])
    else $error("output during flush");
  dec_gap_a: assert property (out_valid |=> !out_valid [*3])
    else $error("outputs too close");
  i_pack_a: assert property (out_valid |-> out_word.i[15:1] == ddc_q.i[15:1])
    else $error("i word bits wrong");
  q_pack_a: assert property (out_valid |-> out_word.q[15:1] == ddc_q.q[15:1])
    else $error("q word bits wrong");
  quiet_flags_a: assert property (out_valid && quiet_q > 9'h104 && thr_q[7:0] != 8'h00
    && thr_q[15:8] != 8'h00 |-> !out_word.i[0] && !out_word.q[0])
    else $error("flag set on quiet input");
  loud_flags_a: assert property (out_valid && loud_q > 9'h104 |-> out_word.i[0] && out_word.q[0])
    else $error("flag clear on full scale");
  cover property (out_valid && out_word.i[0]);
  cover property (link_restart);
  cover property (irq);
endmodule // ovr_embed_chk
bind adc_overrange_flag_embedder ovr_embed_chk #(.FLUSH_SAMPLES(FLUSH_SAMPLES)) chk (
  .ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .raw_sample(raw_sample), .ddc_word(ddc_word), .ddc_valid(ddc_valid),
  .out_word(out_word), .out_valid(out_valid), .tx_drive_en(tx_drive_en),
  .link_restart(link_restart), .irq(irq));
`default_nettype wire

/* File: dv/rx_gain_model.sv */
// downstream receiver model steering gain from the embedded flags
// assumes the block's registered stream on the sample clock
`timescale 1ns/1ps
`default_nettype none
module rx_gain_model (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire ovr_pkg::iq_word_t out_word,
  input  wire logic              out_valid,
  input  wire logic              tx_drive_en,
  input  wire logic              link_restart,
  output logic [3:0]             gain_q
);
  logic       synced_q;
  logic [7:0] calm_q;
  always_ff @(posedge ref_clk) begin
    if (rst || link_restart) synced_q <= 1'b0;
    else if (tx_drive_en && out_valid) synced_q <= 1'b1;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gain_q <= 4'h8;
      calm_q <= 8'h00;
    end else if (synced_q && out_valid) begin
      calm_q <= out_word.q[0] ? 8'h00 : calm_q + 8'h01;
      if (out_word.i[0] && gain_q != 4'h0) gain_q <= gain_q - 4'h1;
      else if (calm_q == 8'hFF && gain_q != 4'hF) gain_q <= gain_q + 4'h1;
    end
  end
endmodule // rx_gain_model
`default_nettype wire

/* File: dv/test_adc_overrange_flag_embedder.sv */
// bench for the over-range flag embedder
// assumes design package, constants header and receiver model
`include "ovr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module test_adc_overrange_flag_embedder;
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  ovr_pkg::reg_req_t reg_req = '0;
  logic [11:0]       raw_sample = 12'h800;
  ovr_pkg::iq_word_t ddc_word = '0;
  logic              ddc_valid = 1'b0;
  logic [31:0]       reg_rdata;
  ovr_pkg::iq_word_t out_word;
  logic              out_valid, tx_drive_en, link_restart, irq;
  logic [3:0]        gain;
  logic [31:0]       rv;
  int                err_count = 0;
  int                n_compared = 0;
  int                cycles = 0;
  int                cnt;
  int                dec_n [8] = '{4, 8, 10, 16, 20, 32, 32, 32};
  logic [13:0]       tbl [7] = '{{12'h800, 2'b00}, {12'hFFF, 2'b11}, {12'h000, 2'b11},
    {12'h010, 2'b01}, {12'hFF0, 2'b01}, {12'hFEF, 2'b00}, {12'h7F8, 2'b00}};
  adc_overrange_flag_embedder #(.FLUSH_SAMPLES(4)) uut (.ref_clk(ref_clk), .rst(rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .raw_sample(raw_sample), .ddc_word(ddc_word),
    .ddc_valid(ddc_valid), .out_word(out_word), .out_valid(out_valid),
    .tx_drive_en(tx_drive_en), .link_restart(link_restart), .irq(irq));
  rx_gain_model rx (.ref_clk(ref_clk), .rst(rst), .out_word(out_word), .out_valid(out_valid),
    .tx_drive_en(tx_drive_en), .link_restart(link_restart), .gain_q(gain));
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) ddc_word <= ddc_word + 32'h0003_0005;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge ref_clk);
    reg_req.we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
    @(posedge ref_clk);
    reg_req.re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // back-to-back status reads, counting cycles with the high flag set
  task automatic poll(input int n, output int hits);
    hits = 0;
    @(posedge ref_clk);
    reg_req <= '{addr: `OVR_REG_STAT, wdata: 32'h0, we: 1'b0, re: 1'b1};
    repeat (n) begin
      @(posedge ref_clk);
      #1 hits += reg_rdata[0];
    end
    @(posedge ref_clk);
    reg_req.re <= 1'b0;
  endtask
  task automatic wait_out(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (out_valid !== 1'b1 && n < 200);
    if (out_valid !== 1'b1) err_count++;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    ddc_valid <= 1'b1;
    rd(`OVR_REG_THR, rv);
    check("thr reset", rv, 32'h0000_40E4);
    rd(8'hFC, rv);
    check("unmapped read", rv, 32'h0);
    wr(`OVR_REG_THR, 32'h0000_FFFE);
    foreach (tbl[i]) begin
      @(posedge ref_clk);
      raw_sample <= tbl[i][13:2];
      repeat (20) @(posedge ref_clk);
      rd(`OVR_REG_STAT, rv);
      check("stat flags", {30'h0, rv[1:0]}, {30'h0, tbl[i][1:0]});
      wait_out(cnt);
      check("embedded flags", {30'h0, out_word.q[0], out_word.i[0]}, {30'h0, tbl[i][1:0]});
    end
    check("receiver gain lowered", {31'h0, gain < 4'h8}, 32'h1);
    foreach (dec_n[s]) begin
      wr(`OVR_REG_CTRL, 32'(s) << 4);
      wait_out(cnt);
      wait_out(cnt);
      wait_out(cnt);
      check("output spacing", cnt, dec_n[s]);
    end
    @(posedge ref_clk);
    raw_sample <= 12'h800;
    wr(`OVR_REG_THR, 32'h0000_FFFF);
    for (int n = 0; n < 8; n++) begin
      wr(`OVR_REG_CTRL, 32'(n) << 1);
      repeat (300) @(posedge ref_clk);
      raw_sample <= 12'h000;
      @(posedge ref_clk);
      raw_sample <= 12'h800;
      poll(300, cnt);
      check("flag hold cycles", cnt, 32'h1 << n);
    end
    wr(`OVR_REG_CTRL, 32'h1);
    cnt = 0;
    repeat (50) begin
      @(posedge ref_clk);
      #1 cnt += out_valid;
    end
    check("outputs in power-down", cnt, 0);
    check("driver in power-down", tx_drive_en, 1'b0);
    wr(`OVR_REG_CTRL, 32'h0);
    cnt = 0;
    repeat (10) begin
      @(posedge ref_clk);
      #1 cnt += link_restart;
    end
    check("link restarts", cnt, 1);
    repeat (30) @(posedge ref_clk);
    check("driver after restart", tx_drive_en, 1'b1);
    wr(`OVR_REG_IRQ_MSK, 32'h0);
    wr(`OVR_REG_IRQ_ST, 32'h7);
    raw_sample <= 12'hFFF;
    repeat (280) @(posedge ref_clk);
    raw_sample <= 12'h800;
    repeat (6) @(posedge ref_clk);
    check("masked irq", irq, 1'b0);
    rd(`OVR_REG_IRQ_ST, rv);
    check("irq status", {30'h0, rv[1:0]}, 32'h3);
    wr(`OVR_REG_IRQ_MSK, 32'h1);
    repeat (3) @(posedge ref_clk);
    check("unmasked irq", irq, 1'b1);
    wr(`OVR_REG_IRQ_ST, 32'h7);
    repeat (3) @(posedge ref_clk);
    check("cleared irq", irq, 1'b0);
    summarize();
  end
endmodule // test_adc_overrange_flag_embedder
`default_nettype wire

/* File: src/adc_overrange_flag_embedder.sv */
// over-range detector and flag embedder with power-down handling
// assumes raw samples and ddc words arrive on ref_clk from on-chip logic
//
// Implementation choices: the address-and-strobe port and the register addresses.
`include "ovr_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_overrange_flag_embedder #(
  parameter int          FLUSH_SAMPLES = 64,
  parameter logic [31:0] ID_VALUE      = 32'h0A5C_0001  // arbitrary value
) (
  input  wire  logic             ref_clk,
  input  wire  logic             rst,
  input  wire  ovr_pkg::reg_req_t reg_req,
  output logic [31:0]            reg_rdata,
  input  wire  logic [11:0]      raw_sample,
  input  wire  ovr_pkg::iq_word_t ddc_word,
  input  wire  logic             ddc_valid,
  output ovr_pkg::iq_word_t      out_word,
  output logic                   out_valid,
  output logic                   tx_drive_en,
  output logic                   link_restart,
  output logic                   irq
);

  if (FLUSH_SAMPLES < 1 || FLUSH_SAMPLES > 65535) begin : g_chk
    $error("FLUSH_SAMPLES out of range");
  end

  // header field layout must match the register widths
  if ((`OVR_CTRL_PER_HI - `OVR_CTRL_PER_LO != 2) ||
      (`OVR_CTRL_DEC_HI - `OVR_CTRL_DEC_LO != 2)) begin : g_ctrl_chk
    $error("control field layout does not match the register widths");
  end
  if ((`OVR_THR_HI_HI - `OVR_THR_HI_LO != 7) ||
      (`OVR_THR_LO_HI - `OVR_THR_LO_LO != 7)) begin : g_thr_chk
    $error("threshold field layout does not match the register widths");
  end
  if (`OVR_IRQ_FLUSH != 2 || `OVR_IRQ_LOW != 1 || `OVR_IRQ_HIGH != 0) begin : g_irq_chk
    $error("interrupt bit layout does not match the status register");
  end

  localparam logic [15:0] FLUSH_LAST = 16'(FLUSH_SAMPLES - 1);

  // control registers
  logic        power_down_control_q;
  logic [2:0]  monitor_period_exponent_q;
  logic [2:0]  dec_sel_q;
  logic [7:0]  overrange_threshold_high_q;
  logic [7:0]  overrange_threshold_low_q;
  logic [2:0]  irq_status_q;
  logic [2:0]  irq_mask_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // datapath state
  logic [7:0]  mag8_q;
  logic        mag_vld_q;
  logic [6:0]  win_cnt_q;
  logic        acc_high_q;
  logic        acc_low_q;
  logic        overrange_flag_high_q;
  logic        overrange_flag_low_q;
  logic [5:0]  dec_cnt_q;
  logic [15:0] flush_cnt_q;
  ovr_pkg::link_state_t state_q;
  ovr_pkg::iq_word_t    out_q;
  logic        out_vld_q;
  logic        tx_en_q;
  logic        restart_q;
  logic        irq_q;

  // combinational helpers
  logic [10:0] mag_d;
  logic [6:0]  win_last;
  logic        win_end;
  logic        hit_high;
  logic        hit_low;
  logic [5:0]  dec_factor;
  logic        wr_ctrl;
  logic        wr_irq_st;
  logic [2:0]  irq_set;
  logic        flush_done;

  assign wr_ctrl   = reg_req.we && (reg_req.addr == `OVR_REG_CTRL);
  assign wr_irq_st = reg_req.we && (reg_req.addr == `OVR_REG_IRQ_ST);

  // magnitude of offset-binary sample, saturating at the bottom code
  always_comb begin
    if (raw_sample[11]) begin
      mag_d = raw_sample[10:0];
    end else if (raw_sample == `OVR_ZERO_CODE) begin
      mag_d = `OVR_MAG_SAT;
    end else begin
      mag_d = 11'(`OVR_MID_CODE - raw_sample);
    end
  end

  // threshold compare on the upper 8 magnitude bits
  assign hit_high = mag_vld_q && (mag8_q >= overrange_threshold_high_q);
  assign hit_low  = mag_vld_q && (mag8_q >= overrange_threshold_low_q);

  // window of 2^n samples
  assign win_last = 7'((8'h01 << monitor_period_exponent_q) - 8'h01);
  assign win_end  = mag_vld_q && (win_cnt_q == win_last);

  always_comb begin
    case (dec_sel_q)
      3'h0:    dec_factor = `OVR_DEC_4;
      3'h1:    dec_factor = `OVR_DEC_8;
      3'h2:    dec_factor = `OVR_DEC_10;
      3'h3:    dec_factor = `OVR_DEC_16;
      3'h4:    dec_factor = `OVR_DEC_20;
      3'h5:    dec_factor = `OVR_DEC_32;
      default: dec_factor = `OVR_DEC_32;
    endcase
  end

  assign flush_done = (state_q == ovr_pkg::ST_FLUSH) && (flush_cnt_q == FLUSH_LAST);

  assign irq_set = {flush_done,
                    win_end && (acc_low_q || hit_low),
                    win_end && (acc_high_q || hit_high)};

  // control register writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      power_down_control_q      <= 1'b0;
      monitor_period_exponent_q <= `OVR_RST_PER;
      dec_sel_q                 <= `OVR_RST_DEC;
    end else if (wr_ctrl) begin
      power_down_control_q      <= reg_req.wdata[`OVR_CTRL_PD];
      monitor_period_exponent_q <= reg_req.wdata[`OVR_CTRL_PER_HI:`OVR_CTRL_PER_LO];
      dec_sel_q                 <= reg_req.wdata[`OVR_CTRL_DEC_HI:`OVR_CTRL_DEC_LO];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      overrange_threshold_high_q <= `OVR_RST_THR_HI;
      overrange_threshold_low_q  <= `OVR_RST_THR_LO;
    end else if (reg_req.we && (reg_req.addr == `OVR_REG_THR)) begin
      overrange_threshold_high_q <= reg_req.wdata[`OVR_THR_HI_HI:`OVR_THR_HI_LO];
      overrange_threshold_low_q  <= reg_req.wdata[`OVR_THR_LO_HI:`OVR_THR_LO_LO];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_mask_q <= 3'h0;
    end else if (reg_req.we && (reg_req.addr == `OVR_REG_IRQ_MSK)) begin
      irq_mask_q <= reg_req.wdata[2:0];
    end
  end

  // one sticky bit per event, set wins over write-one-to-clear
  for (genvar b = 0; b < 3; b++) begin : g_sticky
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        irq_status_q[b] <= 1'b0;
      end else if (irq_set[b]) begin
        irq_status_q[b] <= 1'b1;
      end else if (wr_irq_st && reg_req.wdata[b]) begin
        irq_status_q[b] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  // read mux, zero when no read strobe
  always_comb begin
    rdata_d = 32'h0;
    if (reg_req.re) begin
      case (reg_req.addr)
        `OVR_REG_CTRL:    rdata_d = {25'h0, dec_sel_q, monitor_period_exponent_q,
                                     power_down_control_q};
        `OVR_REG_THR:     rdata_d = {16'h0, overrange_threshold_low_q,
                                     overrange_threshold_high_q};
        `OVR_REG_STAT:    rdata_d = {24'h0, 1'b0, state_q, tx_en_q, out_vld_q,
                                     overrange_flag_low_q, overrange_flag_high_q};
        `OVR_REG_IRQ_ST:  rdata_d = {29'h0, irq_status_q};
        `OVR_REG_IRQ_MSK: rdata_d = {29'h0, irq_mask_q};
        `OVR_REG_ID:      rdata_d = ID_VALUE;
        default:          rdata_d = 32'h0;
      endcase
    end
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // magnitude stage, fed by every raw sample while powered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mag8_q    <= 8'h0;
      mag_vld_q <= 1'b0;
    end else begin
      mag8_q    <= mag_d[10:3];
      mag_vld_q <= !power_down_control_q;
    end
  end

  // window counter
  always_ff @(posedge ref_clk) begin
    if (rst || power_down_control_q) begin
      win_cnt_q <= 7'h0;
    end else if (win_end) begin
      win_cnt_q <= 7'h0;
    end else if (wr_ctrl) begin
      win_cnt_q <= 7'h0;
    end else if (mag_vld_q) begin
      win_cnt_q <= 7'(win_cnt_q + 7'h01);
    end
  end

  // accumulate over the window, publish and clear at its end
  always_ff @(posedge ref_clk) begin
    if (rst || power_down_control_q) begin
      acc_high_q            <= 1'b0;
      acc_low_q             <= 1'b0;
      overrange_flag_high_q <= 1'b0;
      overrange_flag_low_q  <= 1'b0;
    end else if (win_end) begin
      overrange_flag_high_q <= acc_high_q || hit_high;
      overrange_flag_low_q  <= acc_low_q || hit_low;
      acc_high_q            <= 1'b0;
      acc_low_q             <= 1'b0;
    end else if (wr_ctrl) begin
      acc_high_q            <= 1'b0;
      acc_low_q             <= 1'b0;
    end else begin
      acc_high_q            <= acc_high_q || hit_high;
      acc_low_q             <= acc_low_q || hit_low;
    end
  end

  // power state: off, flushing after wake, running
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ovr_pkg::ST_OFF;
    end else begin
      case (state_q)
        ovr_pkg::ST_OFF: begin
          if (!power_down_control_q) begin
            state_q <= ovr_pkg::ST_FLUSH;
          end
        end
        ovr_pkg::ST_FLUSH: begin
          if (power_down_control_q) begin
            state_q <= ovr_pkg::ST_OFF;
          end else if (flush_done) begin
            state_q <= ovr_pkg::ST_RUN;
          end
        end
        ovr_pkg::ST_RUN: begin
          if (power_down_control_q) begin
            state_q <= ovr_pkg::ST_OFF;
          end
        end
        default: state_q <= ovr_pkg::ST_OFF;
      endcase
    end
  end

  // flush counter
  always_ff @(posedge ref_clk) begin
    if (rst || state_q != ovr_pkg::ST_FLUSH) begin
      flush_cnt_q <= 16'h0;
    end else if (!flush_done) begin
      flush_cnt_q <= 16'(flush_cnt_q + 16'h0001);
    end
  end

  // link restart pulse on leaving power-down
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= (state_q == ovr_pkg::ST_OFF) && !power_down_control_q;
    end
  end

  // serial drivers off in power-down
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_en_q <= 1'b0;
    end else begin
      tx_en_q <= !power_down_control_q && (state_q != ovr_pkg::ST_OFF);
    end
  end

  // decimation of the ddc stream
  always_ff @(posedge ref_clk) begin
    if (rst || state_q == ovr_pkg::ST_OFF) begin
      dec_cnt_q <= 6'h0;
    end else if (ddc_valid) begin
      if (dec_cnt_q >= 6'(dec_factor - 6'h01)) begin
        dec_cnt_q <= 6'h0;
      end else begin
        dec_cnt_q <= 6'(dec_cnt_q + 6'h01);
      end
    end
  end

  // output word with flags in the lsb of each half
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_q     <= '0;
      out_vld_q <= 1'b0;
    end else if (ddc_valid && dec_cnt_q == 6'h0 && state_q == ovr_pkg::ST_RUN
                 && !power_down_control_q) begin
      out_q.i   <= {ddc_word.i[15:1], overrange_flag_high_q};
      out_q.q   <= {ddc_word.q[15:1], overrange_flag_low_q};
      out_vld_q <= 1'b1;
    end else begin
      out_vld_q <= 1'b0;
    end
  end

  assign reg_rdata    = rdata_q;
  assign out_word     = out_q;
  assign out_valid    = out_vld_q;
  assign tx_drive_en  = tx_en_q;
  assign link_restart = restart_q;
  assign irq          = irq_q;

endmodule // adc_overrange_flag_embedder

`default_nettype wire

/* File: src/ovr_consts.svh */
// constants for the over-range flag embedder: offsets, fields, resets
// assumes a single sample clock and a plain strobe register port
//
// How it works
// - every raw 12-bit converter sample feeds the detector before down-conversion.
// - offset-binary sample becomes 11-bit magnitude; most negative code saturates to 2047.
// - upper 8 magnitude bits compare against two separate 8-bit thresholds.
// - a flag is 1 if any compared value met its threshold in the window.
// - window length is 2 to the power of a 3-bit setting, 1 to 128 samples.
// - each I output word is upper 15 I bits with the high flag as LSB.
// - each Q output word is upper 15 Q bits with the low flag as LSB.
// - while power-down is high all serial output drivers are disabled.
// - leaving power-down restarts the link and flushes stale pipeline samples.
// - one output sample is 15-bit I, 15-bit Q and two flags, 32 bits.
// - the output stream is decimated by 4, 8, 10, 16, 20 or 32.
`ifndef OVR_CONSTS_SVH
`define OVR_CONSTS_SVH

`define OVR_REG_CTRL     8'h00
`define OVR_REG_THR      8'h04
`define OVR_REG_STAT     8'h08
`define OVR_REG_IRQ_ST   8'h0C
`define OVR_REG_IRQ_MSK  8'h10
`define OVR_REG_ID       8'h14

`define OVR_CTRL_PD      0
`define OVR_CTRL_PER_LO  1
`define OVR_CTRL_PER_HI  3
`define OVR_CTRL_DEC_LO  4
`define OVR_CTRL_DEC_HI  6

`define OVR_THR_HI_LO    0
`define OVR_THR_HI_HI    7
`define OVR_THR_LO_LO    8
`define OVR_THR_LO_HI    15

`define OVR_IRQ_HIGH     0
`define OVR_IRQ_LOW      1
`define OVR_IRQ_FLUSH    2

`define OVR_RST_PER      3'h0
`define OVR_RST_DEC      3'h0
`define OVR_RST_THR_HI   8'hE4
`define OVR_RST_THR_LO   8'h40

`define OVR_MID_CODE     12'h800
`define OVR_ZERO_CODE    12'h000
`define OVR_MAG_SAT      11'h7FF

`define OVR_DEC_4        6'h04
`define OVR_DEC_8        6'h08
`define OVR_DEC_10       6'h0A
`define OVR_DEC_16       6'h10
`define OVR_DEC_20       6'h14
`define OVR_DEC_32       6'h20

`endif

/* File: src/ovr_pkg.sv */
// types shared by the over-range flag embedder
// assumes the constants header for all numeric values
package ovr_pkg;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } iq_word_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } reg_req_t;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_FLUSH = 3'b010,
    ST_RUN   = 3'b100
  } link_state_t;

endpackage
